// ---- include/tmr16_regs.vh ----
/*
 * Register indices, field positions, reset values and divider counts
 * of the 16-bit timer. Assumes a 32-bit Avalon-MM slave in which
 * each register index maps to byte address four times the index.
 */
`ifndef TMR16_REGS_VH
`define TMR16_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address = 4 * index)
`define TMR16_IDX_COUNT 16'hFF10
`define TMR16_IDX_CCA 16'hFF11
`define TMR16_IDX_CCB 16'hFF12
`define TMR16_IDX_MODE 16'hFF13
`define TMR16_IDX_CCCTRL 16'hFF14
`define TMR16_IDX_PRESC 16'hFF15
`define TMR16_IDX_OUTCTRL 16'hFF16
`define TMR16_IDX_P5DIR 16'hFF25
`define TMR16_IDX_P5BIT 16'hFF26

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define TMR16_RST_P5DIR 8'hFF
`define TMR16_RST_PRESC 8'h00
`define TMR16_RST_MODE 2'h0
`define TMR16_RST_CCCTRL 3'h0
`define TMR16_RST_OUTCTRL 1'h0
`define TMR16_RST_WORD 16'h0000

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TMR16_PRESC_CLK_LO 0
`define TMR16_PRESC_CLK_HI 1
`define TMR16_PRESC_ESA_LO 4
`define TMR16_PRESC_ESA_HI 5
`define TMR16_PRESC_ESB_LO 6
`define TMR16_PRESC_ESB_HI 7
`define TMR16_CC_A_CAPTURE 0
`define TMR16_CC_A_FROM_A 1
`define TMR16_CC_B_CAPTURE 2
`define TMR16_P5BIT_VALUE 8
`define TMR16_PIN_OUT_A 4
`define TMR16_PIN_OUT_B 6

////////////////////////////////////////////////////////////////////////////////
// Operating modes
`define TMR16_MODE_STOP 2'h0
`define TMR16_MODE_FREE 2'h1
`define TMR16_MODE_INTERVAL 2'h2
`define TMR16_MODE_PULSE_GEN 2'h3

////////////////////////////////////////////////////////////////////////////////
// Count clock select and edge select codes
`define TMR16_CLK_DIV1 2'h0
`define TMR16_CLK_DIV4 2'h1
`define TMR16_CLK_DIV32 2'h2
`define TMR16_CLK_EXT 2'h3
`define TMR16_EDGE_FALL 2'h0
`define TMR16_EDGE_RISE 2'h1
`define TMR16_EDGE_NONE 2'h2
`define TMR16_EDGE_BOTH 2'h3

////////////////////////////////////////////////////////////////////////////////
// Prescaler terminal counts (divide by 4, 16, 32)
`define TMR16_DIV4_LAST 5'h03
`define TMR16_DIV16_LAST 5'h0F
`define TMR16_DIV32_LAST 5'h1F

`endif

// ---- rtl/tmr16_edge_filt.v ----
/*
 * Two-sample noise filter and edge detector for one capture input.
 * Assumes the input is synchronous to mclk and that sample_tick pulses
 * once per count clock.
 */
`timescale 1ns/10ps

module tmr16_edge_filt (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire sample_tick,
    input wire din,
    output reg rise_reg,
    output reg fall_reg
);

reg sample_reg;
reg level_reg;

////////////////////////////////////////////////////////////////////////////////
// Level reset low: a pin already high at start shows as a rising edge
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        sample_reg <= 1'b0;
        level_reg <= 1'b0;
        rise_reg <= 1'b0;
        fall_reg <= 1'b0;
    end else if (ce) begin
        rise_reg <= 1'b0;
        fall_reg <= 1'b0;
        if (sample_tick) begin
            sample_reg <= din;
            // New level accepted only when seen on two samples in a row
            if (din == sample_reg && din != level_reg) begin // see RL15
                level_reg <= din;
                rise_reg <= din;
                fall_reg <= ~din;
            end
        end
    end
end

endmodule // tmr16_edge_filt

// ---- rtl/tmr16_top.v ----
/*
 * 16-bit timer with two capture/compare registers: interval timer,
 * pulse generator, free-running capture modes, and port 5 direction.
 * Assumes an Avalon-MM master on the register port, capture inputs
 * synchronous to mclk, and a 100 MHz mclk.
 */
// Register access over Avalon-MM was left to the implementer.
// Contract
// RL1: Direction bit 0 drives pin, 1 inputs.
// RL2: Port direction register resets to all ones.
// RL3: Direction register takes bit and byte writes.
// RL4: Software clears direction bit and latch first.
// RL5: Interval mode clears on match, raises request.
// RL6: Interval equals compare plus one count clocks.
// RL7: Count clock chosen by prescaler bits 0-1.
// RL8: Clock codes: fx, fx/4, fx/32, external.
// RL9: Pulse mode: register A period, B width.
// RL10: Software keeps 0 < B < A.
// RL11: Period A+1, high time B+1 clocks.
// RL12: Edge on input A captures into B.
// RL13: Input A edge chosen by bits 4-5.
// RL14: Edge codes: fall, rise, prohibited, both.
// RL15: Edge accepted after two equal samples.
// RL16: Input B edge captures into A, requests.
// RL17: Opposite input A edge captures into A.
// RL18: Two-register mode allows rise or fall only.
// RL19: Both edges selected: A never captures.
// RL20: Free-run counter wraps, ignores matches.
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tmr16_top (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [17:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire capture_in_a,
    input wire capture_in_b,
    output reg pulse_out,
    output wire pulse_out_oe_n,
    output wire [7:0] port5_dir,
    output reg irq_match_a,
    output reg irq_capture_b
);

// Bus states, one-hot
localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_DONE = 2'b10;

reg [1:0] bus_state_reg;
reg [7:0] port5_direction_reg;
reg [15:0] timer_count_reg;
reg [15:0] cap_cmp_a_reg;
reg [15:0] cap_cmp_b_reg;
reg [1:0] timer_mode_ctrl_reg;
reg [2:0] cap_cmp_ctrl_reg;
reg [7:0] prescale_mode_reg;
reg timer_out_ctrl_reg;
reg [4:0] div_reg;
reg pulse_level_reg;
reg [15:0] count_next;
reg pulse_next;
reg [31:0] read_mux;
wire [15:0] reg_idx;
wire wr_go;
wire [1:0] clk_sel;
wire [1:0] edge_sel_a;
wire [1:0] edge_sel_b;
wire running;
wire compare_mode;
wire match_a;
wire match_b;
wire tick_int;
wire tick_sample;
wire count_tick;
wire [1:0] rise_w;
wire [1:0] fall_w;
wire [1:0] pin_w;
wire edge_a_valid;
wire edge_a_opposite;
wire edge_b_valid;
wire do_cap_a;
wire do_cap_b;

////////////////////////////////////////////////////////////////////////////////
// Edge select decode, used for both inputs and for the opposite edge
function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
        case (sel)
            `TMR16_EDGE_FALL: edge_hit = fall;
            `TMR16_EDGE_RISE: edge_hit = rise;
            `TMR16_EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0; // see RL14
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Prescaler and count clock
assign clk_sel = prescale_mode_reg[`TMR16_PRESC_CLK_HI:`TMR16_PRESC_CLK_LO]; // see RL7
assign edge_sel_a = prescale_mode_reg[`TMR16_PRESC_ESA_HI:`TMR16_PRESC_ESA_LO]; // see RL13
assign edge_sel_b = prescale_mode_reg[`TMR16_PRESC_ESB_HI:`TMR16_PRESC_ESB_LO]; // see RL16

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        div_reg <= 5'h00;
    end else if (ce) begin
        div_reg <= div_reg + 5'h01;
    end
end

// see RL8
assign tick_int = (clk_sel == `TMR16_CLK_DIV1) ? 1'b1 :
                  (clk_sel == `TMR16_CLK_DIV4) ? (div_reg[1:0] == `TMR16_DIV4_LAST) :
                  (clk_sel == `TMR16_CLK_DIV32) ? (div_reg == `TMR16_DIV32_LAST) :
                  1'b0;
// External count clock: its own input needs a free internal sampling rate
assign tick_sample = (clk_sel == `TMR16_CLK_EXT) ?
                     (div_reg[3:0] == `TMR16_DIV16_LAST) : tick_int; // see RL15
assign count_tick = (clk_sel == `TMR16_CLK_EXT) ? edge_a_valid : tick_int;

////////////////////////////////////////////////////////////////////////////////
// Capture input filters
assign pin_w = {capture_in_b, capture_in_a};

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
        tmr16_edge_filt u_filt (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .sample_tick(tick_sample),
            .din(pin_w[gi]),
            .rise_reg(rise_w[gi]),
            .fall_reg(fall_w[gi])
        );
    end
endgenerate

assign edge_a_valid = edge_hit(edge_sel_a, rise_w[0], fall_w[0]);
assign edge_b_valid = edge_hit(edge_sel_b, rise_w[1], fall_w[1]);
// Inverting the low bit swaps rise and fall; both and prohibited give none
assign edge_a_opposite = (edge_sel_a == `TMR16_EDGE_RISE || edge_sel_a == `TMR16_EDGE_FALL) &&
                         edge_hit(edge_sel_a ^ 2'b01, rise_w[0], fall_w[0]); // see RL17, RL18, RL19

////////////////////////////////////////////////////////////////////////////////
// Counter
assign running = (timer_mode_ctrl_reg != `TMR16_MODE_STOP);
assign compare_mode = (timer_mode_ctrl_reg == `TMR16_MODE_INTERVAL) ||
                      (timer_mode_ctrl_reg == `TMR16_MODE_PULSE_GEN);
assign match_a = compare_mode && !cap_cmp_ctrl_reg[`TMR16_CC_A_CAPTURE] &&
                 (timer_count_reg == cap_cmp_a_reg);
assign match_b = (timer_count_reg == cap_cmp_b_reg);

always @* begin
    count_next = timer_count_reg;
    if (!running) begin
        count_next = `TMR16_RST_WORD;
    end else if (count_tick) begin
        if (match_a) begin
            count_next = `TMR16_RST_WORD; // see RL5, RL6
        end else begin
            count_next = timer_count_reg + 16'h0001; // see RL20
        end
    end
end

// High from the clear at 0 through count B, low until the next clear
always @* begin
    pulse_next = pulse_level_reg;
    if (timer_mode_ctrl_reg != `TMR16_MODE_PULSE_GEN) begin
        pulse_next = 1'b0;
    end else if (count_tick) begin
        if (match_a) begin
            pulse_next = 1'b1; // see RL9, RL11
        end else if (match_b) begin
            pulse_next = 1'b0; // see RL11
        end
    end
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        timer_count_reg <= `TMR16_RST_WORD;
        pulse_level_reg <= 1'b0;
        pulse_out <= 1'b0;
        irq_match_a <= 1'b0;
        irq_capture_b <= 1'b0;
    end else if (ce) begin
        timer_count_reg <= count_next;
        pulse_level_reg <= pulse_next;
        pulse_out <= pulse_next & timer_out_ctrl_reg;
        irq_match_a <= (running && count_tick && match_a) || do_cap_a; // see RL5, RL16
        irq_capture_b <= do_cap_b; // see RL12
    end
end

////////////////////////////////////////////////////////////////////////////////
// Capture triggers
assign do_cap_b = running && cap_cmp_ctrl_reg[`TMR16_CC_B_CAPTURE] && edge_a_valid; // see RL12
assign do_cap_a = running && cap_cmp_ctrl_reg[`TMR16_CC_A_CAPTURE] &&
                  (cap_cmp_ctrl_reg[`TMR16_CC_A_FROM_A] ? edge_a_opposite : edge_b_valid);

////////////////////////////////////////////////////////////////////////////////
// Avalon slave: one wait cycle on every access
assign reg_idx = avs_address[17:2];
assign avs_waitrequest = (avs_read | avs_write) & bus_state_reg[0];
assign wr_go = ce & avs_write & bus_state_reg[1];

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        bus_state_reg <= ST_IDLE;
    end else if (ce) begin
        case (bus_state_reg)
            ST_IDLE: begin
                if (avs_read | avs_write) begin
                    bus_state_reg <= ST_DONE;
                end
            end
            ST_DONE: bus_state_reg <= ST_IDLE;
            default: bus_state_reg <= ST_IDLE;
        endcase
    end
end

always @* begin
    read_mux = 32'h0000_0000;
    case (reg_idx)
        `TMR16_IDX_COUNT: read_mux[15:0] = timer_count_reg;
        `TMR16_IDX_CCA: read_mux[15:0] = cap_cmp_a_reg;
        `TMR16_IDX_CCB: read_mux[15:0] = cap_cmp_b_reg;
        `TMR16_IDX_MODE: read_mux[1:0] = timer_mode_ctrl_reg;
        `TMR16_IDX_CCCTRL: read_mux[2:0] = cap_cmp_ctrl_reg;
        `TMR16_IDX_PRESC: read_mux[7:0] = prescale_mode_reg;
        `TMR16_IDX_OUTCTRL: read_mux[0] = timer_out_ctrl_reg;
        `TMR16_IDX_P5DIR: read_mux[7:0] = port5_direction_reg;
        default: read_mux = 32'h0000_0000;
    endcase
end

// Read data sampled in the wait cycle, stands while the request is held
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && bus_state_reg[0]) begin
        avs_readdata <= read_mux;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes; a capture in the same cycle wins over software
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        port5_direction_reg <= `TMR16_RST_P5DIR; // see RL2
        cap_cmp_a_reg <= `TMR16_RST_WORD;
        cap_cmp_b_reg <= `TMR16_RST_WORD;
        timer_mode_ctrl_reg <= `TMR16_RST_MODE;
        cap_cmp_ctrl_reg <= `TMR16_RST_CCCTRL;
        prescale_mode_reg <= `TMR16_RST_PRESC;
        timer_out_ctrl_reg <= `TMR16_RST_OUTCTRL;
    end else if (ce) begin
        if (wr_go) begin
            case (reg_idx)
                `TMR16_IDX_CCA: begin
                    if (avs_byteenable[0]) cap_cmp_a_reg[7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1]) cap_cmp_a_reg[15:8] <= avs_writedata[15:8];
                end
                `TMR16_IDX_CCB: begin
                    if (avs_byteenable[0]) cap_cmp_b_reg[7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1]) cap_cmp_b_reg[15:8] <= avs_writedata[15:8];
                end
                `TMR16_IDX_MODE: begin
                    if (avs_byteenable[0]) timer_mode_ctrl_reg <= avs_writedata[1:0];
                end
                `TMR16_IDX_CCCTRL: begin
                    if (avs_byteenable[0]) cap_cmp_ctrl_reg <= avs_writedata[2:0];
                end
                `TMR16_IDX_PRESC: begin
                    if (avs_byteenable[0]) prescale_mode_reg <= avs_writedata[7:0];
                end
                `TMR16_IDX_OUTCTRL: begin
                    if (avs_byteenable[0]) timer_out_ctrl_reg <= avs_writedata[0];
                end
                `TMR16_IDX_P5DIR: begin
                    if (avs_byteenable[0]) port5_direction_reg <= avs_writedata[7:0]; // see RL3
                end
                `TMR16_IDX_P5BIT: begin
                    // Single-bit write: index in bits 2:0, value in bit 8
                    if (avs_byteenable[0] && avs_byteenable[1]) begin
                        port5_direction_reg[avs_writedata[2:0]] <=
                            avs_writedata[`TMR16_P5BIT_VALUE]; // see RL3
                    end
                end
                default: begin
                end
            endcase
        end
        if (do_cap_a) begin
            cap_cmp_a_reg <= timer_count_reg; // see RL16, RL17
        end
        if (do_cap_b) begin
            cap_cmp_b_reg <= timer_count_reg; // see RL12
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin direction; the output latch itself lives in the port block
assign port5_dir = port5_direction_reg; // see RL1
// Active-low enable: 0 means output buffer on, as the direction bit reads
assign pulse_out_oe_n = port5_direction_reg[`TMR16_PIN_OUT_A]; // see RL1, RL4

endmodule // tmr16_top

// ---- verif/tmr16_chk_sva.sv ----
/*
 * Concurrent checks on the 16-bit timer's top-level ports.
 * Assumes ce drops only while the timer is idle and inputs hold for two count clocks.
 */
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tmr16_chk (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [17:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire capture_in_a,
    input wire pulse_out,
    input wire pulse_out_oe_n,
    input wire [7:0] port5_dir,
    input wire irq_match_a,
    input wire irq_capture_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_wait;
        (avs_read || avs_write) && avs_waitrequest && ce;
    endsequence
    sequence s_dir_wr;
        avs_write && !avs_waitrequest && avs_address[17:2] == `TMR16_IDX_P5DIR && avs_byteenable[0];
    endsequence

    property p_oe_dir;
        pulse_out_oe_n == port5_dir[4];
    endproperty
    property p_dir_reset;
        $fell(rst) |-> port5_dir == 8'hff;
    endproperty
    property p_dir_write;
        s_dir_wr |=> port5_dir == $past(avs_writedata[7:0]);
    endproperty
    property p_dir_hold;
        !(avs_write && !avs_waitrequest) |=> $stable(port5_dir);
    endproperty
    property p_bus_answer;
        s_wait |=> !avs_waitrequest;
    endproperty
    property p_rd_upper;
        avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    property p_irqa_pulse;
        irq_match_a |=> !irq_match_a;
    endproperty
    // Two equal samples must precede any accepted edge
    property p_irqb_filter;
        irq_capture_b |-> $past(capture_in_a, 2) == $past(capture_in_a, 3) && !$past(irq_capture_b);
    endproperty
    property p_pulse_hold;
        $rose(pulse_out) |=> pulse_out;
    endproperty

    a_oe_dir: assert property (p_oe_dir) else $error("pin enable differs from direction bit");
    a_dir_reset: assert property (p_dir_reset) else $error("direction not all ones after reset");
    a_dir_write: assert property (p_dir_write) else $error("direction byte write lost");
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed without write");
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
    a_irqa_pulse: assert property (p_irqa_pulse) else $error("match request longer than one cycle");
    a_irqb_filter: assert property (p_irqb_filter) else $error("capture without two samples");
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse high for one cycle only");
endmodule // tmr16_chk

bind tmr16_top tmr16_chk u_chk (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_in_a(capture_in_a), .pulse_out(pulse_out),
    .pulse_out_oe_n(pulse_out_oe_n), .port5_dir(port5_dir), .irq_match_a(irq_match_a),
    .irq_capture_b(irq_capture_b));

// ---- verif/tmr16_pulse_src.sv ----
/*
 * External pulse sources and pulse output load of the timer.
 * Assumes the bench sets the wanted input levels just after an mclk edge.
 */
`timescale 1ns/10ps

module tmr16_pulse_src (
    input wire mclk,
    input wire rst,
    input wire lvl_a,
    input wire lvl_b,
    input wire pulse_out,
    input wire pulse_out_oe_n,
    output logic capture_in_a,
    output logic capture_in_b,
    output logic meas_v,
    output logic [15:0] hi_len,
    output logic [15:0] lo_len
);
    logic [15:0] run_reg;
    logic prev_reg;
    logic seen_reg;
    wire pin;

    // Load sees the pin only while the buffer is on
    assign pin = !pulse_out_oe_n && pulse_out;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            capture_in_a <= 1'b0;
            capture_in_b <= 1'b0;
            meas_v <= 1'b0;
            hi_len <= 16'h0000;
            lo_len <= 16'h0000;
            run_reg <= 16'h0000;
            prev_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            capture_in_a <= lvl_a;
            capture_in_b <= lvl_b;
            meas_v <= 1'b0;
            prev_reg <= pin;
            if (pin != prev_reg) begin
                run_reg <= 16'h0001;
                if (prev_reg) begin
                    hi_len <= run_reg;
                    seen_reg <= 1'b1;
                end else if (seen_reg) begin
                    lo_len <= run_reg;
                    meas_v <= 1'b1;
                end
            end else begin
                run_reg <= run_reg + 16'h0001;
            end
        end
    end
endmodule // tmr16_pulse_src

// ---- verif/tb.sv ----
/*
 * Self-checking bench of the 16-bit timer: registers, interval, pulse
 * generator and capture modes. Assumes the design answers each bus access.
 */
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [17:0] avs_address = 18'h0_0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;
    wire [31:0] avs_readdata;
    wire [7:0] port5_dir;
    wire [15:0] hi_len, lo_len;
    wire avs_waitrequest, capture_in_a, capture_in_b, pulse_out, pulse_out_oe_n;
    wire irq_match_a, irq_capture_b, meas_v;
    int num_errors = 0, compares = 0, cyc = 0, cnt_a = 0, cnt_b = 0, last_a = 0;
    logic [63:0] q_rd[$];
    logic [31:0] q_int[$], q_pls[$];

    always #5 mclk = ~mclk;

    tmr16_top u_dut (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .capture_in_a(capture_in_a), .capture_in_b(capture_in_b), .pulse_out(pulse_out),
        .pulse_out_oe_n(pulse_out_oe_n), .port5_dir(port5_dir), .irq_match_a(irq_match_a),
        .irq_capture_b(irq_capture_b));
    tmr16_pulse_src u_src (.mclk(mclk), .rst(rst), .lvl_a(lvl_a), .lvl_b(lvl_b),
        .pulse_out(pulse_out), .pulse_out_oe_n(pulse_out_oe_n), .capture_in_a(capture_in_a),
        .capture_in_b(capture_in_b), .meas_v(meas_v), .hi_len(hi_len), .lo_len(lo_len));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares=%0d errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Reads push {mask, expected}; the monitor compares at the answering edge
    task automatic bus(input bit wr, input [15:0] idx, input [31:0] d, input [31:0] m,
                       output logic [31:0] v);
        avs_address <= {idx, 2'b00};
        avs_writedata <= wr ? d : 32'h0000_0000;
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr) q_rd.push_back({m, d});
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input [15:0] idx, input [31:0] d);
        logic [31:0] v;
        bus(1'b1, idx, d, 32'h0, v);
    endtask
    task automatic rd(input [15:0] idx, input [31:0] e);
        logic [31:0] v;
        bus(1'b0, idx, e, 32'hffff_ffff, v);
    endtask
    task automatic rdv(input [15:0] idx, output logic [31:0] v);
        bus(1'b0, idx, 32'h0, 32'h0, v);
    endtask
    task automatic settle;
        for (int i = 0; i < 4000 && (q_int.size() + q_pls.size()) > 0; i++) @(posedge mclk);
        check(q_int.size() + q_pls.size(), 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        logic [63:0] e;
        cyc <= cyc + 1;
        if (avs_read && avs_waitrequest === 1'b0 && q_rd.size() > 0) begin
            e = q_rd.pop_front();
            check(avs_readdata & e[63:32], e[31:0]);
        end
        if (irq_match_a === 1'b1) begin
            cnt_a <= cnt_a + 1;
            last_a <= cyc;
            if (q_int.size() > 0) check(cyc - last_a, q_int.pop_front());
        end
        if (irq_capture_b === 1'b1) cnt_b <= cnt_b + 1;
        if (meas_v === 1'b1 && q_pls.size() > 0) check({hi_len, lo_len}, q_pls.pop_front());
    end

    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        stop_test;
    end

    initial begin
        logic [31:0] v, a, b, v2, v4, ca;
        int n, t, t2, t4;
        int dv[3] = '{1, 4, 32};
        int code[3] = '{0, 1, 3};
        int ncap[3] = '{2, 2, 4};
        v = $urandom(94252);
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(`TMR16_IDX_P5DIR, 32'h0000_00ff);
        check(pulse_out_oe_n, 1'b1);
        v = $urandom() & 32'h0000_00ff;
        wr(`TMR16_IDX_P5DIR, v);
        rd(`TMR16_IDX_P5DIR, v);
        check(pulse_out_oe_n, v[4]);
        wr(`TMR16_IDX_P5BIT, 32'h0000_0004);
        rd(`TMR16_IDX_P5DIR, v & 32'h0000_00ef);
        rd(16'hff30, 32'h0000_0000);
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            a = 1 + ($urandom() % 8);
            wr(`TMR16_IDX_PRESC, k);
            wr(`TMR16_IDX_CCA, a);
            wr(`TMR16_IDX_MODE, `TMR16_MODE_INTERVAL);
            n = cnt_a;
            for (int i = 0; i < 2000 && cnt_a == n; i++) @(posedge mclk);
            repeat (3) q_int.push_back((a + 1) * dv[k]);
            settle();
            wr(`TMR16_IDX_MODE, `TMR16_MODE_STOP);
        end
        $display("interval test done");
        b = 1 + ($urandom() % 6);
        a = b + 1 + ($urandom() % 6);
        wr(`TMR16_IDX_PRESC, 0);
        wr(`TMR16_IDX_CCA, a);
        wr(`TMR16_IDX_CCB, b);
        wr(`TMR16_IDX_OUTCTRL, 1);
        wr(`TMR16_IDX_MODE, `TMR16_MODE_PULSE_GEN);
        repeat (2) q_pls.push_back({b[15:0] + 16'h0001, a[15:0] - b[15:0]});
        settle();
        wr(`TMR16_IDX_MODE, `TMR16_MODE_STOP);
        $display("pulse test done");
        // Compare value kept small so a stray clear would spoil the difference
        wr(`TMR16_IDX_CCA, 3);
        wr(`TMR16_IDX_CCCTRL, 4);
        for (int k = 0; k < 3; k++) begin
            wr(`TMR16_IDX_PRESC, code[k] << 4);
            wr(`TMR16_IDX_MODE, `TMR16_MODE_FREE);
            n = cnt_b;
            for (int j = 1; j <= 4; j++) begin
                t = cyc;
                lvl_a <= !lvl_a;
                repeat (15) @(posedge mclk);
                rdv(`TMR16_IDX_CCB, v);
                if (j == 2) {v2, t2} = {v, t};
                if (j == 4) {v4, t4} = {v, t};
                repeat (20) @(posedge mclk);
            end
            check((v4 - v2) & 32'h0000_ffff, t4 - t2);
            check(cnt_b - n, ncap[k]);
            wr(`TMR16_IDX_MODE, `TMR16_MODE_STOP);
        end
        wr(`TMR16_IDX_PRESC, 32'h0000_0050);
        wr(`TMR16_IDX_MODE, `TMR16_MODE_FREE);
        for (int w = 1; w <= 2; w++) begin
            n = cnt_b;
            lvl_a <= 1'b1;
            repeat (w) @(posedge mclk);
            lvl_a <= 1'b0;
            repeat (10) @(posedge mclk);
            check(cnt_b - n, w - 1);
        end
        wr(`TMR16_IDX_CCCTRL, 5);
        n = cnt_a;
        lvl_b <= 1'b1;
        repeat (10) @(posedge mclk);
        check(cnt_a - n, 1);
        lvl_b <= 1'b0;
        wr(`TMR16_IDX_CCCTRL, 7);
        for (int k = 0; k < 2; k++) begin
            rdv(`TMR16_IDX_CCA, ca);
            t = cyc;
            lvl_a <= 1'b1;
            repeat (20) @(posedge mclk);
            t2 = cyc;
            lvl_a <= 1'b0;
            repeat (20) @(posedge mclk);
            rdv(`TMR16_IDX_CCA, a);
            rdv(`TMR16_IDX_CCB, b);
            if (k == 0) check((a - b) & 32'h0000_ffff, t2 - t);
            else check(a, ca);
            wr(`TMR16_IDX_MODE, `TMR16_MODE_STOP);
            wr(`TMR16_IDX_PRESC, 32'h0000_0030);
            wr(`TMR16_IDX_MODE, `TMR16_MODE_FREE);
        end
        rdv(`TMR16_IDX_COUNT, a);
        ce <= 1'b0;
        repeat (10) @(posedge mclk);
        ce <= 1'b1;
        rdv(`TMR16_IDX_COUNT, b);
        check((b - a) & 32'h0000_ffff, 3);
        wr(`TMR16_IDX_MODE, `TMR16_MODE_STOP);
        wr(`TMR16_IDX_PRESC, `TMR16_CLK_EXT);
        wr(`TMR16_IDX_MODE, `TMR16_MODE_FREE);
        repeat (4) begin
            lvl_a <= !lvl_a;
            repeat (40) @(posedge mclk);
        end
        rdv(`TMR16_IDX_COUNT, v);
        check(v, 2);
        $display("capture test done");
        stop_test;
    end
endmodule // tb
